/* rtl/pie_defs.vh */
// Purpose: Constants for the peripheral interrupt flag and enable bank.
// Assumes: AXI4-Lite register access with 32-bit data, one word per register.
// Notes: Offsets are byte addresses.
`ifndef PIE_DEFS_VH
`define PIE_DEFS_VH

`define PIE_ADDR_W 4
`define PIE_OFS_FLAGS1 4'h0
`define PIE_OFS_FLAGS2 4'h4
`define PIE_OFS_EN1 4'h8
`define PIE_OFS_EN2 4'hC
`define PIE_REG_RST 8'h00
`define PIE_RESP_OKAY 2'b00
`define PIE_RESP_DECERR 2'b11

`define PIE_B_PARPORT 7
`define PIE_B_CONV 6
`define PIE_B_RXFULL 5
`define PIE_B_TXEMPTY 4
`define PIE_B_SYNCSER 3
`define PIE_B_CAPCOMP1 2
`define PIE_B_PERIOD 1
`define PIE_B_TMR1OVF 0

`define PIE_B_OSCFAIL 7
`define PIE_B_COMPCHG 6
`define PIE_B_USB 5
`define PIE_B_NVDONE 4
`define PIE_B_BUSCOLL 3
`define PIE_B_VOLTDET 2
`define PIE_B_TMR3OVF 1
`define PIE_B_CAPCOMP2 0

`define PIE_CCP_MODE_CAPTURE 2'b00
`define PIE_CCP_MODE_COMPARE 2'b01
`define PIE_CCP_MODE_PWM 2'b10

`endif

/* rtl/pie_flag_bank.v */
// Purpose: Two 8-bit peripheral request flag registers with matching enables,
//          reached over AXI4-Lite, combined into one peripheral request output.
// Assumes: Event inputs are one-cycle pulses from logic on ref_clk; buffer
//          status levels come from the serial port on ref_clk.
// Notes: Flags except first-bank bits 5 and 4 are sticky; software clears by writing 0; a set wins over a clear.
//
// What this block does
// RQ1 - Parallel-port transfer done sets bit 7, sticky.
// RQ2 - Conversion done sets bit 6, sticky.
// RQ3 - Bit 5 mirrors receive buffer full, read-only.
// RQ4 - Bit 4 mirrors transmit buffer empty, read-only.
// RQ5 - Sync serial transfer done sets bit 3, sticky.
// RQ6 - Capture/compare one sets bit 2, not PWM.
// RQ7 - Timer two period match sets bit 1.
// RQ8 - Timer one overflow sets bit 0.
// RQ9 - Software keeps bit 7 clear on small packages.
// RQ10 - Oscillator fail sets second bit 7, sticky.
// RQ11 - Comparator output change sets second bit 6.
// RQ12 - USB combined request sets second bit 5.
// RQ13 - Nonvolatile write done sets second bit 4.
// RQ14 - Bus collision sets second bit 3, sticky.
// RQ15 - Voltage detect sets second bit 2, sticky.
// RQ16 - Timer three overflow sets second bit 1.
// RQ17 - Capture/compare two sets bit 0, not PWM.
// RQ18 - Enable bit gates same-position request flag.
// RQ19 - Without priorities, peripheral gate must be set.
// RQ20 - Flags set regardless of any enable.
// RQ21 - With priorities, gate enables low-priority peripherals.
// RQ22 - Per-source priority applies only with priorities on.
// RQ23 - Flag AND enable, ORed into one request.

`include "pie_defs.vh"

module pie_flag_bank #(
    parameter ADDR_W = `PIE_ADDR_W
) (
    input wire ref_clk, // System clock.
    input wire sys_rst, // Asynchronous reset, active high.
    input wire [ADDR_W-1:0] s_axi_awaddr, // Write address.
    input wire s_axi_awvalid, // Write address valid.
    output reg s_axi_awready, // Write address ready.
    input wire [31:0] s_axi_wdata, // Write data.
    input wire [3:0] s_axi_wstrb, // Write byte strobes.
    input wire s_axi_wvalid, // Write data valid.
    output reg s_axi_wready, // Write data ready.
    output reg [1:0] s_axi_bresp, // Write response.
    output reg s_axi_bvalid, // Write response valid.
    input wire s_axi_bready, // Write response ready.
    input wire [ADDR_W-1:0] s_axi_araddr, // Read address.
    input wire s_axi_arvalid, // Read address valid.
    output reg s_axi_arready, // Read address ready.
    output reg [31:0] s_axi_rdata, // Read data.
    output reg [1:0] s_axi_rresp, // Read response.
    output reg s_axi_rvalid, // Read data valid.
    input wire s_axi_rready, // Read data ready.
    input wire parPortXferDone, // Parallel port transfer complete pulse.
    input wire convDone, // Conversion finished pulse.
    input wire rxBufFull, // Serial receive buffer holds data.
    input wire txBufEmpty, // Serial transmit buffer is empty.
    input wire syncSerialDone, // Sync serial transfer complete pulse.
    input wire [1:0] ccpOneMode, // Capture/compare one mode.
    input wire ccpOneCapture, // Capture/compare one capture pulse.
    input wire ccpOneMatch, // Capture/compare one compare match pulse.
    input wire timerTwoPeriodMatch, // Timer two equals its period pulse.
    input wire timerOneOverflow, // Timer one overflow pulse.
    input wire oscFail, // Oscillator fail, switched to internal oscillator.
    input wire [1:0] compOut, // Comparator outputs.
    input wire usbIrq, // USB combined interrupt pulse.
    input wire nvWriteDone, // Nonvolatile write complete pulse.
    input wire busCollision, // Sync serial bus collision pulse.
    input wire voltDetect, // Voltage detector event pulse.
    input wire timerThreeOverflow, // Timer three overflow pulse.
    input wire [1:0] ccpTwoMode, // Capture/compare two mode.
    input wire ccpTwoCapture, // Capture/compare two capture pulse.
    input wire ccpTwoMatch, // Capture/compare two compare match pulse.
    input wire priorityLevelsOn, // Priority levels enabled.
    input wire peripheralIrqGate, // Peripheral gate or low-priority gate.
    input wire [7:0] priority1, // Per-source priority, first bank, 1 high.
    input wire [7:0] priority2, // Per-source priority, second bank, 1 high.
    output reg periphIrq_q, // Any enabled request, gated per mode.
    output reg periphIrqHigh_q, // High-priority peripheral request.
    output reg periphIrqLow_q // Low-priority peripheral request; every gated request when priority levels are off.
);

    reg [7:0] flags1_q;
    reg [7:0] flags2_q;
    reg [7:0] en1_q;
    reg [7:0] en2_q;
    reg [1:0] compOut_q;
    reg oscFail_q;
    reg [ADDR_W-1:0] wAddr_q;
    reg wAddrHave_q;
    reg [31:0] wData_q;
    reg [3:0] wStrb_q;
    reg wDataHave_q;

    wire awTake = s_axi_awvalid && s_axi_awready;
    wire wTake = s_axi_wvalid && s_axi_wready;
    wire wGo = wAddrHave_q && wDataHave_q && !s_axi_bvalid;
    wire wLane0 = wGo && wStrb_q[0];
    wire wrFlags1 = wLane0 && (wAddr_q == `PIE_OFS_FLAGS1);
    wire wrFlags2 = wLane0 && (wAddr_q == `PIE_OFS_FLAGS2);
    wire wrEn1 = wLane0 && (wAddr_q == `PIE_OFS_EN1);
    wire wrEn2 = wLane0 && (wAddr_q == `PIE_OFS_EN2);
    wire wMapped = (wAddr_q == `PIE_OFS_FLAGS1) || (wAddr_q == `PIE_OFS_FLAGS2) ||
        (wAddr_q == `PIE_OFS_EN1) || (wAddr_q == `PIE_OFS_EN2);

    // Event sets for each bank; PWM mode raises no capture/compare event.
    reg [7:0] set1;
    reg [7:0] set2;
    always @* begin
        set1 = 8'h00;
        set2 = 8'h00;
        set1[`PIE_B_PARPORT] = parPortXferDone; // [RQ1]
        set1[`PIE_B_CONV] = convDone; // [RQ2]
        set1[`PIE_B_SYNCSER] = syncSerialDone; // [RQ5]
        set1[`PIE_B_CAPCOMP1] = ((ccpOneMode == `PIE_CCP_MODE_CAPTURE) && ccpOneCapture) ||
            ((ccpOneMode == `PIE_CCP_MODE_COMPARE) && ccpOneMatch); // [RQ6]
        set1[`PIE_B_PERIOD] = timerTwoPeriodMatch; // [RQ7]
        set1[`PIE_B_TMR1OVF] = timerOneOverflow; // [RQ8]
        set2[`PIE_B_OSCFAIL] = oscFail && !oscFail_q; // [RQ10]
        set2[`PIE_B_COMPCHG] = (compOut != compOut_q); // [RQ11]
        set2[`PIE_B_USB] = usbIrq; // [RQ12]
        set2[`PIE_B_NVDONE] = nvWriteDone; // [RQ13]
        set2[`PIE_B_BUSCOLL] = busCollision; // [RQ14]
        set2[`PIE_B_VOLTDET] = voltDetect; // [RQ15]
        set2[`PIE_B_TMR3OVF] = timerThreeOverflow; // [RQ16]
        set2[`PIE_B_CAPCOMP2] = ((ccpTwoMode == `PIE_CCP_MODE_CAPTURE) && ccpTwoCapture) ||
            ((ccpTwoMode == `PIE_CCP_MODE_COMPARE) && ccpTwoMatch); // [RQ17]
    end

    // Sticky flags: a write keeps or clears a bit, a same-cycle event wins.
    reg [7:0] flags1_d;
    reg [7:0] flags2_d;
    always @* begin
        flags1_d = (wrFlags1 ? (flags1_q & wData_q[7:0]) : flags1_q) | set1; // [RQ20]
        flags1_d[`PIE_B_RXFULL] = rxBufFull; // [RQ3]
        flags1_d[`PIE_B_TXEMPTY] = txBufEmpty; // [RQ4]
        flags2_d = (wrFlags2 ? (flags2_q & wData_q[7:0]) : flags2_q) | set2; // [RQ20]
    end

    // Requests per source and their priority split.
    wire [7:0] req1 = flags1_q & en1_q; // [RQ18]
    wire [7:0] req2 = flags2_q & en2_q; // [RQ18]
    wire anyReq = |{req1, req2}; // [RQ23]
    wire anyHigh = |{req1 & priority1, req2 & priority2}; // [RQ22]
    wire anyLow = |{req1 & ~priority1, req2 & ~priority2}; // [RQ22]

    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            flags1_q <= `PIE_REG_RST;
            flags2_q <= `PIE_REG_RST;
            en1_q <= `PIE_REG_RST;
            en2_q <= `PIE_REG_RST;
            compOut_q <= 2'b00;
            oscFail_q <= 1'b0;
            periphIrq_q <= 1'b0;
            periphIrqHigh_q <= 1'b0;
            periphIrqLow_q <= 1'b0;
        end else begin
            flags1_q <= flags1_d;
            flags2_q <= flags2_d;
            compOut_q <= compOut;
            oscFail_q <= oscFail;
            if (wrEn1) begin
                en1_q <= wData_q[7:0]; // [RQ18]
            end
            if (wrEn2) begin
                en2_q <= wData_q[7:0]; // [RQ18]
            end
            if (priorityLevelsOn) begin
                periphIrq_q <= anyHigh || (anyLow && peripheralIrqGate); // [RQ21]
                periphIrqHigh_q <= anyHigh; // [RQ22]
                periphIrqLow_q <= anyLow && peripheralIrqGate; // [RQ21]
            end else begin
                periphIrq_q <= anyReq && peripheralIrqGate; // [RQ19]
                periphIrqHigh_q <= 1'b0;
                periphIrqLow_q <= anyReq && peripheralIrqGate; // [RQ19]
            end
        end
    end

    // Write channel: address and data taken in either order, then a response.
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PIE_RESP_OKAY;
            wAddr_q <= {ADDR_W{1'b0}};
            wAddrHave_q <= 1'b0;
            wData_q <= 32'h00000000;
            wStrb_q <= 4'h0;
            wDataHave_q <= 1'b0;
        end else begin
            s_axi_awready <= !wAddrHave_q && !awTake && !s_axi_bvalid;
            s_axi_wready <= !wDataHave_q && !wTake && !s_axi_bvalid;
            if (awTake) begin
                wAddr_q <= s_axi_awaddr;
                wAddrHave_q <= 1'b1;
            end
            if (wTake) begin
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
                wDataHave_q <= 1'b1;
            end
            if (wGo) begin
                wAddrHave_q <= 1'b0;
                wDataHave_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wMapped ? `PIE_RESP_OKAY : `PIE_RESP_DECERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Read channel.
    reg [31:0] rdMux;
    reg rdMapped;
    always @* begin
        rdMux = 32'h00000000;
        rdMapped = 1'b1;
        case (s_axi_araddr)
            `PIE_OFS_FLAGS1: rdMux[7:0] = flags1_q;
            `PIE_OFS_FLAGS2: rdMux[7:0] = flags2_q;
            `PIE_OFS_EN1: rdMux[7:0] = en1_q;
            `PIE_OFS_EN2: rdMux[7:0] = en2_q;
            default: rdMapped = 1'b0;
        endcase
    end

    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `PIE_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rdMux;
                s_axi_rresp <= rdMapped ? `PIE_RESP_OKAY : `PIE_RESP_DECERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule // pie_flag_bank

/* tb/pie_flag_bank_props.sv */
// Purpose: Concurrent checks on the bus timing and request outputs of the flag bank.
// Assumes: One clock domain, reset active high.
// Notes: Bound to every instance of the flag bank.
module pie_flag_bank_props #(
    parameter ADDR_W = 4
) (
    input wire ref_clk, // Clock.
    input wire sys_rst, // Reset.
    input wire s_axi_awvalid, // AW valid.
    input wire s_axi_awready, // AW ready.
    input wire s_axi_wvalid, // W valid.
    input wire s_axi_wready, // W ready.
    input wire s_axi_bvalid, // B valid.
    input wire s_axi_bready, // B ready.
    input wire [ADDR_W-1:0] s_axi_araddr, // AR address.
    input wire s_axi_arvalid, // AR valid.
    input wire s_axi_arready, // AR ready.
    input wire [31:0] s_axi_rdata, // R data.
    input wire [1:0] s_axi_rresp, // R response.
    input wire s_axi_rvalid, // R valid.
    input wire s_axi_rready, // R ready.
    input wire priorityLevelsOn, // Priority mode.
    input wire peripheralIrqGate, // Gate.
    input wire periphIrq_q, // Request.
    input wire periphIrqHigh_q, // High request.
    input wire periphIrqLow_q // Low request.
);
    wire wrTake = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);
    a_write_answer: assert property (wrTake |-> ##2 s_axi_bvalid)
        else $error("Write response late.");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("Write response dropped.");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("Read data late.");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
        else $error("Read data changed.");
    a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[1:0] != 0
        |=> s_axi_rresp == 2'b11 && s_axi_rdata == 32'h0) else $error("Bad unmapped read.");
    a_gate_off: assert property (!priorityLevelsOn && !peripheralIrqGate |=> !periphIrq_q)
        else $error("Request passed closed gate.");
    a_high_off: assert property (!priorityLevelsOn |=> !periphIrqHigh_q)
        else $error("High request without priorities.");
    a_low_mirror: assert property (!priorityLevelsOn |=> periphIrqLow_q == periphIrq_q)
        else $error("Low request differs.");
    a_low_gated: assert property (priorityLevelsOn && !peripheralIrqGate
        |=> periphIrq_q == periphIrqHigh_q) else $error("Low request passed gate.");
endmodule // pie_flag_bank_props

bind pie_flag_bank pie_flag_bank_props #(.ADDR_W(ADDR_W)) i_props (.*);

/* tb/pie_periph_model.sv */
// Purpose: Stand-in for the peripherals that raise request events.
// Assumes: The bench asks for events on ref_clk.
// Notes: Each request is registered into a pulse launched at the next edge, lasting as many cycles as it is held.
module pie_periph_model (
    input wire ref_clk, // Clock.
    input wire [7:0] req1, // Requests, first bank.
    input wire [7:0] req2, // Requests, second bank.
    output logic [7:0] ev1 = 8'h00, // Pulses, first bank.
    output logic [7:0] ev2 = 8'h00 // Pulses, second bank.
);
    timeunit 1ns;
    timeprecision 1ps;
    always @(posedge ref_clk) begin
        ev1 <= req1;
        ev2 <= req2;
    end
endmodule // pie_periph_model

/* tb/tb_top.sv */
// Purpose: Self-checking bench for the peripheral flag and enable bank.
// Assumes: Offsets and response codes as defined for the bank.
// Notes: Events reach the bank through the peripheral model.
`include "pie_defs.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0, sys_rst = 1'b1, rxFull = 1'b0, txEmpty = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic priority_levels_on = 1'b0, gate = 1'b0, bvalid, arready, awready, wready, rvalid, irq, hi, lo;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0] bresp, rresp, ccpMode = 2'b00;
    logic [7:0] req1 = 8'h00, req2 = 8'h00, prio1 = 8'h00, ev1, ev2;
    logic [15:0] m;
    logic [3:0] ofs;
    int num_errors = 0, samples_checked = 0, cycles = 0;
    always #2.5 ref_clk = ~ref_clk;
    pie_periph_model i_model (.ref_clk(ref_clk), .req1(req1), .req2(req2), .ev1(ev1), .ev2(ev2));
    pie_flag_bank i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .parPortXferDone(ev1[7]), .convDone(ev1[6]), .rxBufFull(rxFull), .txBufEmpty(txEmpty),
        .syncSerialDone(ev1[3]), .ccpOneMode(ccpMode), .ccpOneCapture(ev1[2]),
        .ccpOneMatch(ev1[5]), .timerTwoPeriodMatch(ev1[1]), .timerOneOverflow(ev1[0]),
        .oscFail(ev2[7]), .compOut({1'b0, ev2[6]}), .usbIrq(ev2[5]), .nvWriteDone(ev2[4]),
        .busCollision(ev2[3]), .voltDetect(ev2[2]), .timerThreeOverflow(ev2[1]),
        .ccpTwoMode(ccpMode), .ccpTwoCapture(ev2[0]), .ccpTwoMatch(ev1[4]),
        .priorityLevelsOn(priority_levels_on), .peripheralIrqGate(gate), .priority1(prio1), .priority2(8'h00),
        .periphIrq_q(irq), .periphIrqHigh_q(hi), .periphIrqLow_q(lo));
    task automatic complete_run();
        $display("Mismatches %0d, checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [3:0] s,
        input logic [1:0] er);
        logic ad;
        logic wd;
        @(posedge ref_clk);
        awaddr <= a;
        wdata <= {24'h000000, d};
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        ad = 1'b0;
        wd = 1'b0;
        while (!(ad && wd)) begin
            @(posedge ref_clk);
            ad = ad | awready;
            wd = wd | wready;
            if (ad) awvalid <= 1'b0;
            if (wd) wvalid <= 1'b0;
        end
        do @(posedge ref_clk); while (!bvalid);
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, er});
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [1:0] er);
        @(posedge ref_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge ref_clk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge ref_clk); while (!rvalid);
        rready <= 1'b0;
        chk(rdata, {24'h000000, e});
        chk({30'h0, rresp}, {30'h0, er});
    endtask
    task automatic fire(input logic [7:0] a, input logic [7:0] b);
        req1 <= a;
        req2 <= b;
        @(posedge ref_clk);
        req1 <= 8'h00;
        req2 <= 8'h00;
        repeat (2) @(posedge ref_clk);
    endtask
    task automatic irqChk(input logic [2:0] e);
        repeat (2) @(posedge ref_clk);
        chk({29'h0, irq, hi, lo}, {29'h0, e});
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            complete_run();
        end
    end
    initial begin
        repeat (5) @(posedge ref_clk);
        sys_rst <= 1'b0;
        for (int k = 0; k < 4; k++) rd(4'(k * 4), `PIE_REG_RST, `PIE_RESP_OKAY);
        rd(4'h2, 8'h00, `PIE_RESP_DECERR);
        wr(4'h6, 8'hFF, 4'hF, `PIE_RESP_DECERR);
        wr(`PIE_OFS_EN1, 8'hA5, 4'hF, `PIE_RESP_OKAY);
        wr(`PIE_OFS_EN2, 8'h5A, 4'hF, `PIE_RESP_OKAY);
        wr(`PIE_OFS_EN1, 8'h00, 4'h0, `PIE_RESP_OKAY);
        rd(`PIE_OFS_EN1, 8'hA5, `PIE_RESP_OKAY);
        rd(`PIE_OFS_EN2, 8'h5A, `PIE_RESP_OKAY);
        wr(`PIE_OFS_EN1, 8'h00, 4'hF, `PIE_RESP_OKAY);
        wr(`PIE_OFS_EN2, 8'h00, 4'hF, `PIE_RESP_OKAY);
        for (int i = 0; i < 16; i++) begin
            if (i == 4 || i == 5) continue;
            m = 16'h0001 << i;
            fire(m[7:0], m[15:8]);
            ofs = (i < 8) ? `PIE_OFS_FLAGS1 : `PIE_OFS_FLAGS2;
            rd(ofs, m[7:0] | m[15:8], `PIE_RESP_OKAY);
            wr(ofs, 8'hFF, 4'hF, `PIE_RESP_OKAY);
            rd(ofs, m[7:0] | m[15:8], `PIE_RESP_OKAY);
            wr(ofs, 8'h00, 4'hF, `PIE_RESP_OKAY);
            rd(ofs, 8'h00, `PIE_RESP_OKAY);
        end
        rxFull <= 1'b1;
        txEmpty <= 1'b1;
        wr(`PIE_OFS_FLAGS1, 8'h00, 4'hF, `PIE_RESP_OKAY);
        rd(`PIE_OFS_FLAGS1, 8'h30, `PIE_RESP_OKAY);
        rxFull <= 1'b0;
        rd(`PIE_OFS_FLAGS1, 8'h10, `PIE_RESP_OKAY);
        txEmpty <= 1'b0;
        rd(`PIE_OFS_FLAGS1, 8'h00, `PIE_RESP_OKAY);
        for (int k = 0; k < 3; k++) begin
            ccpMode <= 2'(k);
            fire(8'h34, 8'h01);
            rd(`PIE_OFS_FLAGS1, (k < 2) ? 8'h04 : 8'h00, `PIE_RESP_OKAY);
            rd(`PIE_OFS_FLAGS2, (k < 2) ? 8'h01 : 8'h00, `PIE_RESP_OKAY);
            wr(`PIE_OFS_FLAGS1, 8'h00, 4'hF, `PIE_RESP_OKAY);
            wr(`PIE_OFS_FLAGS2, 8'h00, 4'hF, `PIE_RESP_OKAY);
        end
        fire(8'h01, 8'h00);
        wr(`PIE_OFS_EN1, 8'h01, 4'hF, `PIE_RESP_OKAY);
        irqChk(3'b000);
        gate <= 1'b1;
        irqChk(3'b101);
        wr(`PIE_OFS_EN1, 8'h02, 4'hF, `PIE_RESP_OKAY);
        irqChk(3'b000);
        wr(`PIE_OFS_EN1, 8'h01, 4'hF, `PIE_RESP_OKAY);
        priority_levels_on <= 1'b1;
        gate <= 1'b0;
        prio1 <= 8'h01;
        irqChk(3'b110);
        prio1 <= 8'h00;
        gate <= 1'b1;
        irqChk(3'b101);
        complete_run();
    end
endmodule // tb_top
